// ==== display_panel.sv ====
`timescale 1ns/1ps
`default_nettype none
// A passive panel: a pixel lights only where its segment is driven on the active common.
module display_panel (
    // Drive lines
    input wire logic [3:0] com_select,
    input wire logic [41:0] seg_drive,
    // Lit pixels of the active common
    output logic [41:0] lit
);
    assign lit = (com_select != 4'h0) ? seg_drive : 42'h0;
endmodule // display_panel
`default_nettype wire

// ==== drive_clock_divider.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_drive_consts.vh"

module drive_clock_divider (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire run,
    input wire [1:0] clk_sel,
    // Drive clock event, one pclk cycle wide
    output reg tick
);

reg [`DIV_CNT_W-1:0] count_reg;
reg [`DIV_CNT_W-1:0] limit;

// The filter clock is pclk here, so the period is 128 * 2^(9 - sel) cycles.
always @* begin
    limit = {`DIV_CNT_W{1'b1}} >> (`DIV_CNT_W - `BASE_DIV_LOG2 - `SEL_DIV_LOG2_MAX + clk_sel);
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_reg <= {`DIV_CNT_W{1'b0}};
        tick <= 1'b0;
    end else if (!run) begin
        count_reg <= {`DIV_CNT_W{1'b0}};
        tick <= 1'b0;
    end else if (count_reg >= limit) begin
        count_reg <= {`DIV_CNT_W{1'b0}};
        tick <= 1'b1;
    end else begin
        count_reg <= count_reg + 1'b1;
        tick <= 1'b0;
    end
end

endmodule // drive_clock_divider
`default_nettype wire

// ==== lcd_drive_consts.vh ====
`ifndef LCD_DRIVE_CONSTS_VH
`define LCD_DRIVE_CONSTS_VH

// Register indices as printed; the APB byte address is four times the index.
`define IDX_BOOST_PIN_SHARE 14'h2020
`define IDX_CLOCK_MODE_EN 14'h2021
`define IDX_FULL_SCALE 14'h2022
`define IDX_SEG_DATA_BASE 14'h2040
`define SEG_COUNT 42
`define SEG_IDX_W 6

// Field positions.
`define BOOST_EN_BIT 7
`define PIN_COUNT_MSB 4
`define PIN_COUNT_LSB 0
`define CLK_SEL_MSB 1
`define CLK_SEL_LSB 0
`define MODE_MSB 4
`define MODE_LSB 2
`define DRIVE_EN_BIT 5
`define FS_MSB 4
`define FS_LSB 0
`define SEG_DATA_MSB 3

// Reset values.
`define RST_PIN_COUNT 5'h00
`define RST_CLK_SEL 2'h0
`define RST_MODE 3'h0
`define RST_FS 5'h00
`define RST_SEG_DATA 4'h0

// Bias modes.
`define MODE_4ST_THIRD 3'h0
`define MODE_3ST_THIRD 3'h1
`define MODE_2ST_HALF 3'h2
`define MODE_3ST_HALF 3'h3
`define MODE_STATIC 3'h4

// Time state counts and limits.
`define STATES_4 2'h3
`define STATES_3 2'h2
`define STATES_2 2'h1
`define STATES_1 2'h0
`define SHARED_PINS 5'h12
`define SHARED_FIRST_SEG 24

// Drive clock: base is filter clock / 128, then / 2^(9 - select).
`define BASE_DIV_LOG2 7
`define SEL_DIV_LOG2_MAX 9
`define DIV_CNT_W 16

// Top rail = supply * (217 + 3 * code) / 310.
`define RAIL_NUM_OFFSET 9'h0d9
`define RAIL_NUM_STEP 9'h003
`define RAIL_DENOM 9'h136

`endif

// ==== lcd_drive_control.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_drive_consts.vh"

module lcd_drive_control (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Analog control
    output reg display_boost_enable,
    output reg bias_rails_on,
    output reg [2:0] bias_mode_applied,
    output reg half_bias,
    output reg [8:0] top_bias_rail_num,
    // Panel drive
    output reg [3:0] com_select,
    output reg drive_polarity,
    output reg [`SEG_COUNT-1:0] seg_drive,
    // Shared pin ownership, bit i is segment 24 + i / I/O 4 + i
    output reg [17:0] shared_pin_is_segment
);

////////////////////////////////////////////////////////////////////////////////

reg [4:0] shared_pin_segment_count_reg;
reg [1:0] display_drive_clock_select_reg;
reg [2:0] display_bias_mode_reg;
reg display_drive_enable_reg;
reg [4:0] display_full_scale_code_reg;
reg [`SEG_DATA_MSB:0] segment_data_word [0:`SEG_COUNT-1];
reg [1:0] time_state_reg;
reg polarity_reg;
wire drive_tick;
wire [13:0] word_idx;
wire access;
wire wr_en;
wire seg_hit;
wire [13:0] seg_off;
wire [`SEG_IDX_W-1:0] seg_idx;
reg [2:0] mode_eff;
reg [1:0] last_state;
reg [4:0] count_eff;
wire hit_pin_share;
wire hit_clock_mode;
wire hit_full_scale;
wire mapped;
reg [31:0] read_word;
integer i;

// Codes above static have no scheme of their own and fall back to static.
function [2:0] effective_mode;
    input [2:0] m;
    begin
        if (m > `MODE_STATIC) begin
            effective_mode = `MODE_STATIC;
        end else begin
            effective_mode = m;
        end
    end
endfunction

function [1:0] final_state;
    input [2:0] m;
    begin
        case (m)
            `MODE_4ST_THIRD: final_state = `STATES_4;
            `MODE_3ST_THIRD: final_state = `STATES_3;
            `MODE_2ST_HALF: final_state = `STATES_2;
            `MODE_3ST_HALF: final_state = `STATES_3;
            default: final_state = `STATES_1;
        endcase
    end
endfunction

function is_reg;
    input [13:0] idx;
    input [13:0] target;
    begin
        is_reg = (idx == target);
    end
endfunction

// Shared position 0 is segment 24; the count claims positions from the top (17) downward.
// Counts are clamped before use, so the subtraction never wraps.
function pin_claimed;
    input integer pos;
    input [4:0] count;
    begin
        pin_claimed = (pos >= (`SHARED_PINS - count));
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// APB access: zero wait states, error on unmapped or unaligned addresses.

assign word_idx = paddr[15:2];
assign seg_off = word_idx - `IDX_SEG_DATA_BASE;
assign seg_hit = (word_idx >= `IDX_SEG_DATA_BASE) && (seg_off < `SEG_COUNT);
assign seg_idx = seg_off[`SEG_IDX_W-1:0];
assign access = psel && penable;
assign pready = 1'b1;
// Each register decode feeds the error, write and read paths alike.
assign hit_pin_share = is_reg(word_idx, `IDX_BOOST_PIN_SHARE);
assign hit_clock_mode = is_reg(word_idx, `IDX_CLOCK_MODE_EN);
assign hit_full_scale = is_reg(word_idx, `IDX_FULL_SCALE);
assign mapped = hit_pin_share || hit_clock_mode || hit_full_scale || seg_hit;
assign pslverr = access && ((paddr[1:0] != 2'h0) || !mapped);
assign wr_en = access && pwrite && !pslverr;

// Register writes land on the access edge; an errored access leaves every field alone.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        display_boost_enable <= 1'b0;
        shared_pin_segment_count_reg <= `RST_PIN_COUNT;
        display_drive_clock_select_reg <= `RST_CLK_SEL;
        display_bias_mode_reg <= `RST_MODE;
        display_drive_enable_reg <= 1'b0;
        display_full_scale_code_reg <= `RST_FS;
        for (i = 0; i < `SEG_COUNT; i = i + 1) begin
            segment_data_word[i] <= `RST_SEG_DATA;
        end
    end else if (wr_en) begin
        if (is_reg(word_idx, `IDX_BOOST_PIN_SHARE)) begin
            display_boost_enable <= pwdata[`BOOST_EN_BIT];
            shared_pin_segment_count_reg <= pwdata[`PIN_COUNT_MSB:`PIN_COUNT_LSB];
        end
        if (is_reg(word_idx, `IDX_CLOCK_MODE_EN)) begin
            display_drive_clock_select_reg <= pwdata[`CLK_SEL_MSB:`CLK_SEL_LSB];
            display_bias_mode_reg <= pwdata[`MODE_MSB:`MODE_LSB];
            display_drive_enable_reg <= pwdata[`DRIVE_EN_BIT];
        end
        if (is_reg(word_idx, `IDX_FULL_SCALE)) begin
            display_full_scale_code_reg <= pwdata[`FS_MSB:`FS_LSB];
        end
        if (seg_hit) begin
            segment_data_word[seg_idx] <= pwdata[`SEG_DATA_MSB:0];
        end
    end
end

// Read data is registered during the setup cycle so it is stable in the access phase.
always @* begin
    read_word = 32'h00000000;
    if (hit_pin_share) begin
        read_word[`BOOST_EN_BIT] = display_boost_enable;
        read_word[`PIN_COUNT_MSB:`PIN_COUNT_LSB] = shared_pin_segment_count_reg;
    end
    if (hit_clock_mode) begin
        read_word[`CLK_SEL_MSB:`CLK_SEL_LSB] = display_drive_clock_select_reg;
        read_word[`MODE_MSB:`MODE_LSB] = display_bias_mode_reg;
        read_word[`DRIVE_EN_BIT] = display_drive_enable_reg;
    end
    if (hit_full_scale) begin
        read_word[`FS_MSB:`FS_LSB] = display_full_scale_code_reg;
    end
    if (seg_hit) begin
        read_word[`SEG_DATA_MSB:0] = segment_data_word[seg_idx];
    end
end

// Unmapped reads return zero because no decode above selects them.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
        prdata <= read_word;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Drive clock and time-state sequencing.

// A select change mid-count only moves the wrap point, so one drive period may stretch or end early.
drive_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(display_drive_enable_reg),
    .clk_sel(display_drive_clock_select_reg),
    .tick(drive_tick)
);

always @* begin
    mode_eff = effective_mode(display_bias_mode_reg);
    last_state = final_state(mode_eff);
    // Counts above 18 are illegal; clamping keeps pins beyond the shared range untouched.
    if (shared_pin_segment_count_reg > `SHARED_PINS) begin
        count_eff = `SHARED_PINS;
    end else begin
        count_eff = shared_pin_segment_count_reg;
    end
end

// Polarity flips after each full frame so the glass sees no net DC.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        time_state_reg <= 2'h0;
        polarity_reg <= 1'b0;
    end else if (!display_drive_enable_reg) begin
        time_state_reg <= 2'h0;
        polarity_reg <= 1'b0;
    end else if (drive_tick) begin
        if (time_state_reg >= last_state) begin
            time_state_reg <= 2'h0;
            polarity_reg <= ~polarity_reg;
        end else begin
            time_state_reg <= time_state_reg + 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered panel and analog outputs.

// Analog controls follow the fields one cycle later, and the rails drop to ground with drive off.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bias_rails_on <= 1'b0;
        bias_mode_applied <= `MODE_STATIC;
        half_bias <= 1'b0;
        top_bias_rail_num <= 9'h000;
    end else begin
        bias_mode_applied <= mode_eff;
        half_bias <= (mode_eff == `MODE_2ST_HALF) || (mode_eff == `MODE_3ST_HALF);
        if (display_drive_enable_reg) begin
            bias_rails_on <= 1'b1;
            top_bias_rail_num <= `RAIL_NUM_OFFSET + `RAIL_NUM_STEP * {4'h0, display_full_scale_code_reg};
        end else begin
            bias_rails_on <= 1'b0;
            top_bias_rail_num <= 9'h000;
        end
    end
end

// Commons and polarity share the segment outputs' timing so the glass never sees a skewed state.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        com_select <= 4'h0;
        drive_polarity <= 1'b0;
    end else if (display_drive_enable_reg) begin
        com_select <= 4'h1 << time_state_reg;
        drive_polarity <= polarity_reg;
    end else begin
        com_select <= 4'h0;
        drive_polarity <= 1'b0;
    end
end

// Segments below the shared range always drive glass; shared ones only once claimed.
genvar g;
generate
    for (g = 0; g < `SEG_COUNT; g = g + 1) begin : g_seg
        wire claimed;
        if (g >= `SHARED_FIRST_SEG) begin : g_shared
            assign claimed = pin_claimed(g - `SHARED_FIRST_SEG, count_eff);
        end else begin : g_fixed
            assign claimed = 1'b1;
        end
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                seg_drive[g] <= 1'b0;
            end else begin
                seg_drive[g] <= display_drive_enable_reg && claimed &&
                    segment_data_word[g][time_state_reg];
            end
        end
    end
endgenerate

// Ownership of each shared pin is registered so the pin mux never sees a decode glitch.
generate
    for (g = 0; g < `SHARED_PINS; g = g + 1) begin : g_pin
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                shared_pin_is_segment[g] <= 1'b0;
            end else begin
                // Claimed from segment 41 downward; the rest stay general I/O.
                shared_pin_is_segment[g] <= pin_claimed(g, count_eff);
            end
        end
    end
endgenerate

endmodule // lcd_drive_control
`default_nettype wire

// ==== lcd_drive_control_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_control_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    // Display outputs
    input wire logic display_boost_enable,
    input wire logic bias_rails_on,
    input wire logic [2:0] bias_mode_applied,
    input wire logic half_bias,
    input wire logic [8:0] top_bias_rail_num,
    input wire logic [3:0] com_select,
    input wire logic [41:0] seg_drive,
    input wire logic [17:0] shared_pin_is_segment
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    a_boost_follow: assert property (wr && paddr == 16'h8080 |=> display_boost_enable == $past(pwdata[7]))
        else $error("boost enable does not follow write");
    a_rails_ground: assert property (!bias_rails_on && $past(!bias_rails_on) |-> top_bias_rail_num == 9'h000
        && com_select == 4'h0 && seg_drive == 42'h0)
        else $error("disabled display not grounded");
    a_rail_span: assert property (bias_rails_on && $past(bias_rails_on) |-> top_bias_rail_num >= 9'h0d9
        && top_bias_rail_num <= 9'h136 && (top_bias_rail_num - 9'h0d9) % 9'h003 == 9'h000)
        else $error("top rail off the linear scale");
    a_half_bias: assert property (half_bias == (bias_mode_applied == 3'h2 || bias_mode_applied == 3'h3))
        else $error("half bias disagrees with mode");
    a_mode_clamp: assert property (bias_mode_applied <= 3'h4)
        else $error("applied mode out of range");
    a_com_onehot: assert property (bias_rails_on && $past(bias_rails_on) |-> $onehot(com_select))
        else $error("active common not one-hot");
    a_pins_top: assert property ($onehot({1'b0, ~shared_pin_is_segment} + 19'h00001))
        else $error("claimed pins not contiguous from top");
    a_unclaimed_io: assert property ((seg_drive[41:24] & ~shared_pin_is_segment) == 18'h00000)
        else $error("unclaimed pin driven as segment");
    cover property (wr && paddr == 16'h8084);
    cover property (bias_rails_on && bias_mode_applied == 3'h4);
    cover property ($rose(com_select[3]));
endmodule // lcd_drive_control_props
bind lcd_drive_control lcd_drive_control_props lcd_drive_control_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .display_boost_enable(display_boost_enable), .bias_rails_on(bias_rails_on),
    .bias_mode_applied(bias_mode_applied), .half_bias(half_bias), .top_bias_rail_num(top_bias_rail_num),
    .com_select(com_select), .seg_drive(seg_drive), .shared_pin_is_segment(shared_pin_is_segment));
`default_nettype wire

// ==== lcd_drive_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, display_boost_enable, bias_rails_on, half_bias, drive_polarity, er;
    logic [2:0] bias_mode_applied;
    logic [8:0] top_bias_rail_num;
    logic [3:0] com_select;
    logic [41:0] seg_drive, lit;
    logic [17:0] shared_pin_is_segment;
    int failures = 0;
    int compares = 0;
    always #12.5 pclk = ~pclk;
    lcd_drive_control lcd_drive_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .display_boost_enable(display_boost_enable), .bias_rails_on(bias_rails_on),
        .bias_mode_applied(bias_mode_applied), .half_bias(half_bias), .top_bias_rail_num(top_bias_rail_num),
        .com_select(com_select), .drive_polarity(drive_polarity), .seg_drive(seg_drive),
        .shared_pin_is_segment(shared_pin_is_segment));
    display_panel display_panel_inst (.com_select(com_select), .seg_drive(seg_drive), .lit(lit));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task complete_run;
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk("pin share reg", 16'h8080, 32'h0);
        rdchk("clock mode reg", 16'h8084, 32'h0);
        rdchk("full scale reg", 16'h8088, 32'h0);
        chk("mode out", bias_mode_applied, 3'h0);
        chk("lit", lit, 42'h0);
    endtask
    task t_regs;
        apb(1'b1, 16'h8080, 32'h92);
        @(posedge pclk);
        chk("boost on", display_boost_enable, 1'b1);
        rdchk("pin share reg", 16'h8080, 32'h92);
        apb(1'b1, 16'h8080, 32'h12);
        @(posedge pclk);
        chk("boost off", display_boost_enable, 1'b0);
        apb(1'b0, 16'h8090, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask
    task t_pins;
        for (int n = 0; n <= 18; n++) begin
            apb(1'b1, 16'h8080, n);
            repeat (2) @(posedge pclk);
            chk("pins", shared_pin_is_segment, 18'h3ffff ^ (18'h3ffff >> n));
        end
    endtask
    task t_modes;
        int fs;
        for (int m = 0; m < 8; m++) begin
            fs = (m == 0) ? 0 : m * 4 + 3;
            apb(1'b1, 16'h8088, fs);
            apb(1'b1, 16'h8084, 32'h23 | (m << 2));
            repeat (3) @(posedge pclk);
            chk("mode", bias_mode_applied, (m > 4) ? 4 : m);
            chk("half", half_bias, m == 2 || m == 3);
            chk("rail", top_bias_rail_num, 217 + 3 * fs);
        end
    endtask
    task measure(input int p);
        int c;
        logic [3:0] last;
        logic pol;
        c = 0;
        last = com_select;
        while (com_select === last && c < p + 8) begin
            @(posedge pclk);
            c++;
        end
        pol = drive_polarity;
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            c = 1;
            last = com_select;
            while (com_select === last && c < p + 8) begin
                @(posedge pclk);
                c++;
            end
            if (k == 1) chk("tick period", c, p);
            chk("seg41", seg_drive[41], |(com_select & 4'h5));
            chk("seg0", seg_drive[0], |(com_select & 4'ha));
            chk("polarity", drive_polarity, (com_select == 4'h1) ? !pol : pol);
            pol = drive_polarity;
        end
    endtask
    task t_drive;
        apb(1'b1, 16'h8100, 32'ha);
        apb(1'b1, 16'h81a4, 32'h5);
        apb(1'b1, 16'h8080, 32'h12);
        apb(1'b1, 16'h8084, 32'h23);
        measure(8192);
        apb(1'b1, 16'h8084, 32'h2a);
        measure(16384);
    endtask
    task t_disable;
        apb(1'b1, 16'h8084, 32'h0);
        repeat (3) @(posedge pclk);
        chk("rails", bias_rails_on, 1'b0);
        chk("rail num", top_bias_rail_num, 9'h000);
        chk("commons", com_select, 4'h0);
        chk("polarity off", drive_polarity, 1'b0);
        chk("segments", seg_drive, 42'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_regs;
        t_pins;
        t_modes;
        t_drive;
        t_disable;
        complete_run;
    end
    // Worst case for the drive clock checks is about 75000 cycles.
    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        complete_run;
    end
endmodule // lcd_drive_control_tb
`default_nettype wire
